// ==== rtl/pcilsr_pkg.sv ====
package pcilsr_pkg;
  // indicator control codes; 2'h0 is reserved
  typedef enum logic [1:0] {
    PCILSR_IND_RSVD = 2'b00,
    PCILSR_IND_ON = 2'b01,
    PCILSR_IND_BLINK = 2'b10,
    PCILSR_IND_OFF = 2'b11
  } pcilsr_ind_e;
  typedef logic [5:0] pcilsr_width_t;
  typedef logic [3:0] pcilsr_speed_t;
endpackage : pcilsr_pkg

// ==== rtl/pcilsr_port_regs.sv ====
// Notes on behaviour
// [R1] max link speed field reads 0001b or 0010b only
// [R2] max link width bits 9:4 report one-hot lane count x1..x8
// [R3] L0s exit latency reads 011b, 256ns to under 512ns
// [R4] L1 exit latency reads 000b, under 1 us
// [R5] capability bit 18 reads 1 upstream, 0 downstream
// [R6] ASPM control selects L0s/L1 entry; receiver L0s always allowed
// [R7] link control bit 4 disables downstream link; upstream hardwired zero
// [R8] writing 1 to bit 5 retrains downstream link; always reads 0
// [R9] bit 7 selects 4096 FTS and 1024 TS1 on exits
// [R10] upstream: bit 8 clear holds clock request low; set permits use
// [R11] status bits 19:16 speed and 25:20 width as negotiated
// [R12] training error set on failure, cleared when link reaches L0
// [R13] link training bit reads 1 while training in progress
// [R14] bit 29 reads 1 only in DL_Active
// [R15] power limit value/scale write sends set-slot-power-limit message
// [R16] hot-plug capable reads 0 without external expander
// [R17] slot control bits 0-3, 11, 12 enable per-source hot-plug events
// [R18] command-completed enable works only when no-command-completed bit is 0
// [R19] slot control bit 5 gates every hot-plug interrupt
// [R20] attention indicator bits 7:6 on/blink/off; write sends message
// [R21] power indicator bits 9:8 likewise; reset depends on latch enable
// [R22] power controller bit 10: 0 power on, 1 power off
// [R23] layer-state-changed flag set whenever link-active indication changes
// [R24] write-one clears a status flag; zero leaves it; events set again
`timescale 1ns/1ns
`default_nettype none
`include "pcilsr_regs.svh"
module pcilsr_port_regs #(
  parameter bit UPSTREAM = 1'b0,
  parameter logic [7:0] PORT_NUMBER = 8'h01,
  parameter logic [12:0] SLOT_NUMBER = 13'h0001,
  parameter bit NO_CMD_CPL = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  // configuration access
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  // straps and loadable defaults
  input wire pcilsr_pkg::pcilsr_width_t strap_max_width,
  input wire logic strap_expander_present,
  // physical and data link layer state
  input wire pcilsr_pkg::pcilsr_speed_t neg_speed,
  input wire pcilsr_pkg::pcilsr_width_t neg_width,
  input wire logic training_active,
  input wire logic training_failed,
  input wire logic link_in_l0,
  input wire logic dl_active,
  // hot-plug event pulses from the slot hardware
  input wire logic ev_attention_button,
  input wire logic ev_power_fault,
  input wire logic ev_retention_latch,
  input wire logic ev_presence_change,
  input wire logic ev_electromech_lock,
  input wire logic ev_cmd_completed,
  // link controls
  output logic link_disable,
  output logic retrain_req,
  output logic aspm_l0s_tx_en,
  output logic aspm_l1_en,
  output logic rx_l0s_allowed,
  output logic [15:0] fts_count,
  output logic [15:0] ts1_count,
  output logic clkreq_hold_low,
  // slot controls and messages
  output logic hotplug_int,
  output logic slot_power_off,
  output logic pwr_limit_msg,
  output logic [7:0] pwr_limit_value,
  output logic [1:0] pwr_limit_scale,
  output logic attn_ind_msg,
  output pcilsr_pkg::pcilsr_ind_e attn_ind,
  output logic pwr_ind_msg,
  output pcilsr_pkg::pcilsr_ind_e pwr_ind
);
  import pcilsr_pkg::*;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr[11:2] == off[11:2]);
  endfunction : hit

  logic wr;
  logic wr_link;
  logic wr_slot_cap;
  logic wr_slot;
  assign wr = cfg_req & cfg_we;
  assign wr_link = wr & hit(cfg_addr, `PCILSR_OFF_LINK_CTL);
  assign wr_slot_cap = wr & hit(cfg_addr, `PCILSR_OFF_SLOT_CAP);
  assign wr_slot = wr & hit(cfg_addr, `PCILSR_OFF_SLOT_CTL) & ~UPSTREAM;

  // ---------------------------------------------------------------
  // straps, caught once after reset release
  // ---------------------------------------------------------------
  logic hardware_initialised;
  pcilsr_width_t max_width;
  logic hp_capable;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hardware_initialised <= 1'b0;
      max_width <= `PCILSR_NEG_WIDTH_RST;
      hp_capable <= 1'b0;
    end else if (!hardware_initialised) begin
      hardware_initialised <= 1'b1;
      max_width <= strap_max_width; // [R2]
      hp_capable <= strap_expander_present & ~UPSTREAM; // [R16]
    end
  end

  // ---------------------------------------------------------------
  // link control
  // ---------------------------------------------------------------
  logic [15:0] link_ctl;
  logic [15:0] next_link_ctl;
  always_comb begin
    next_link_ctl = link_ctl;
    if (cfg_be[0]) begin
      next_link_ctl[1:0] = cfg_wdata[1:0]; // [R6]
      next_link_ctl[`PCILSR_LC_DISABLE] = cfg_wdata[`PCILSR_LC_DISABLE] & ~UPSTREAM; // [R7]
      next_link_ctl[6] = cfg_wdata[6];
      next_link_ctl[`PCILSR_LC_EXT_SYNC] = cfg_wdata[`PCILSR_LC_EXT_SYNC];
    end
    if (cfg_be[1]) begin
      next_link_ctl[`PCILSR_LC_CLK_PM] = cfg_wdata[`PCILSR_LC_CLK_PM] & UPSTREAM;
      next_link_ctl[9] = cfg_wdata[9];
      next_link_ctl[11:10] = UPSTREAM ? 2'h0 : cfg_wdata[11:10];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      link_ctl <= `PCILSR_LINK_CTL_RST;
    end else if (wr_link) begin
      link_ctl <= next_link_ctl;
    end
  end

  // retrain never stored, so it always reads back as zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      retrain_req <= 1'b0;
    end else begin
      retrain_req <= wr_link & cfg_be[0] & cfg_wdata[`PCILSR_LC_RETRAIN] & ~UPSTREAM; // [R8]
    end
  end

  assign link_disable = link_ctl[`PCILSR_LC_DISABLE]; // [R7]
  assign aspm_l0s_tx_en = link_ctl[0]; // [R6]
  assign aspm_l1_en = link_ctl[1]; // [R6]
  assign rx_l0s_allowed = 1'b1; // [R6]
  // zero means the link layer uses its own training defaults
  assign fts_count = link_ctl[`PCILSR_LC_EXT_SYNC] ? `PCILSR_FTS_EXT : 16'h0000; // [R9]
  assign ts1_count = link_ctl[`PCILSR_LC_EXT_SYNC] ? `PCILSR_TS1_EXT : 16'h0000; // [R9]
  assign clkreq_hold_low = UPSTREAM & ~link_ctl[`PCILSR_LC_CLK_PM]; // [R10]

  // ---------------------------------------------------------------
  // link status
  // ---------------------------------------------------------------
  pcilsr_speed_t sts_speed;
  pcilsr_width_t sts_width;
  logic train_err;
  logic training;
  logic dll_active;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sts_speed <= `PCILSR_SPEED_2G5;
      sts_width <= `PCILSR_NEG_WIDTH_RST;
      training <= 1'b0;
      dll_active <= 1'b0;
    end else begin
      // only the documented codes are latched; others keep the last value
      if (neg_speed == `PCILSR_SPEED_2G5 || neg_speed == `PCILSR_SPEED_5G0) begin
        sts_speed <= neg_speed; // [R11]
      end
      if (neg_width != 6'h00 && (neg_width & (neg_width - 6'h01)) == 6'h00 && neg_width <= 6'h08) begin
        sts_width <= neg_width; // [R11]
      end
      training <= training_active; // [R13]
      dll_active <= dl_active; // [R14]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      train_err <= 1'b0;
    end else if (training_failed) begin
      train_err <= 1'b1; // [R12]
    end else if (link_in_l0 && !training_active) begin
      train_err <= 1'b0; // [R12]
    end
  end

  logic [15:0] link_sts;
  always_comb begin
    link_sts = 16'h0000;
    link_sts[3:0] = sts_speed; // [R11]
    link_sts[9:4] = sts_width; // [R11]
    link_sts[`PCILSR_LS_TRAIN_ERR] = train_err;
    link_sts[`PCILSR_LS_TRAINING] = training;
    link_sts[12] = UPSTREAM;
    link_sts[`PCILSR_LS_DLL_ACTIVE] = dll_active;
  end

  // ---------------------------------------------------------------
  // slot power limit
  // ---------------------------------------------------------------
  logic lim_touch;
  assign lim_touch = wr_slot_cap & ~UPSTREAM & (|cfg_be[2:0]);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pwr_limit_value <= `PCILSR_PWR_LIMIT_RST;
      pwr_limit_scale <= `PCILSR_PWR_SCALE_RST;
      pwr_limit_msg <= 1'b0;
    end else begin
      if (lim_touch) begin
        pwr_limit_value <= {cfg_be[1] ? cfg_wdata[14:8] : pwr_limit_value[7:1],
                            cfg_be[0] ? cfg_wdata[7] : pwr_limit_value[0]};
        pwr_limit_scale <= {cfg_be[2] ? cfg_wdata[16] : pwr_limit_scale[1],
                            cfg_be[1] ? cfg_wdata[15] : pwr_limit_scale[0]};
      end
      pwr_limit_msg <= lim_touch; // [R15]
    end
  end

  // ---------------------------------------------------------------
  // slot control
  // ---------------------------------------------------------------
  logic [15:0] slot_ctl;
  logic [15:0] next_slot_ctl;
  logic [15:0] slot_ctl_rst;
  always_comb begin
    slot_ctl_rst = 16'h0000;
    slot_ctl_rst[7:6] = PCILSR_IND_OFF;
    // latch enable resets clear, so the power indicator resets on
    slot_ctl_rst[9:8] = slot_ctl_rst[`PCILSR_SC_LATCH_EN] ? PCILSR_IND_OFF : PCILSR_IND_ON; // [R21]
    slot_ctl_rst[10] = slot_ctl_rst[`PCILSR_SC_LATCH_EN];
  end

  always_comb begin
    next_slot_ctl = slot_ctl;
    if (cfg_be[0]) begin
      next_slot_ctl[7:0] = cfg_wdata[7:0]; // [R17]
    end
    if (cfg_be[1]) begin
      next_slot_ctl[12:8] = cfg_wdata[12:8]; // [R17]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      slot_ctl <= slot_ctl_rst;
      attn_ind_msg <= 1'b0;
      pwr_ind_msg <= 1'b0;
    end else begin
      if (wr_slot) begin
        slot_ctl <= next_slot_ctl;
      end
      attn_ind_msg <= wr_slot & cfg_be[0]; // [R20]
      pwr_ind_msg <= wr_slot & cfg_be[1]; // [R21]
    end
  end

  assign attn_ind = pcilsr_ind_e'(slot_ctl[7:6]); // [R20]
  assign pwr_ind = pcilsr_ind_e'(slot_ctl[9:8]); // [R21]
  assign slot_power_off = slot_ctl[10]; // [R22]

  // ---------------------------------------------------------------
  // layer-state-changed flag and hot-plug interrupt
  // ---------------------------------------------------------------
  logic dll_changed;
  logic dll_edge;
  assign dll_edge = dll_active ^ dl_active; // [R23]
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dll_changed <= 1'b0;
    end else if (dll_edge && !UPSTREAM) begin
      dll_changed <= 1'b1; // [R23] set wins over clear
    end else if (wr_slot && cfg_be[3] && cfg_wdata[16 + `PCILSR_SS_DLL_CHANGED]) begin
      dll_changed <= 1'b0; // [R24]
    end
  end

  logic [6:0] hp_events;
  always_comb begin
    hp_events[0] = ev_attention_button & slot_ctl[0]; // [R17]
    hp_events[1] = ev_power_fault & slot_ctl[1];
    hp_events[2] = ev_retention_latch & slot_ctl[`PCILSR_SC_LATCH_EN];
    hp_events[3] = ev_presence_change & slot_ctl[3];
    hp_events[4] = ev_cmd_completed & slot_ctl[`PCILSR_SC_CMD_CPL_EN] & ~NO_CMD_CPL; // [R18]
    hp_events[5] = ev_electromech_lock & slot_ctl[11];
    hp_events[6] = dll_edge & slot_ctl[12];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hotplug_int <= 1'b0;
    end else begin
      hotplug_int <= ~UPSTREAM & slot_ctl[`PCILSR_SC_HP_INT_EN] & (|hp_events); // [R19]
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(cfg_addr, `PCILSR_OFF_LINK_CAP)) begin
      rd_mux[3:0] = `PCILSR_MAX_SPEED; // [R1]
      rd_mux[9:4] = max_width; // [R2]
      rd_mux[11:10] = `PCILSR_ASPM_SUPPORT;
      rd_mux[14:12] = `PCILSR_L0S_EXIT_LAT; // [R3]
      rd_mux[17:15] = `PCILSR_L1_EXIT_LAT; // [R4]
      rd_mux[18] = UPSTREAM; // [R5]
      rd_mux[21] = ~UPSTREAM;
      rd_mux[31:24] = PORT_NUMBER;
    end else if (hit(cfg_addr, `PCILSR_OFF_LINK_CTL)) begin
      rd_mux = {link_sts, link_ctl}; // [R8] retrain bit is never stored
    end else if (hit(cfg_addr, `PCILSR_OFF_SLOT_CAP) && !UPSTREAM) begin
      rd_mux[4:0] = 5'h1f;
      rd_mux[6] = hp_capable; // [R16]
      rd_mux[14:7] = pwr_limit_value;
      rd_mux[16:15] = pwr_limit_scale;
      rd_mux[18] = NO_CMD_CPL;
      rd_mux[31:19] = SLOT_NUMBER;
    end else if (hit(cfg_addr, `PCILSR_OFF_SLOT_CTL) && !UPSTREAM) begin
      rd_mux[15:0] = slot_ctl;
      rd_mux[16 + `PCILSR_SS_DLL_CHANGED] = dll_changed;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_req;
      cfg_rdata <= (cfg_req && !cfg_we) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule : pcilsr_port_regs
`default_nettype wire

// ==== rtl/pcilsr_regs.svh ====
`ifndef PCILSR_REGS_SVH
`define PCILSR_REGS_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses of the config dwords)
// ---------------------------------------------------------------
`define PCILSR_OFF_LINK_CAP 12'h074
`define PCILSR_OFF_LINK_CTL 12'h078
`define PCILSR_OFF_SLOT_CAP 12'h07c
`define PCILSR_OFF_SLOT_CTL 12'h080
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PCILSR_LC_DISABLE 4
`define PCILSR_LC_RETRAIN 5
`define PCILSR_LC_EXT_SYNC 7
`define PCILSR_LC_CLK_PM 8
`define PCILSR_LS_TRAIN_ERR 10
`define PCILSR_LS_TRAINING 11
`define PCILSR_LS_DLL_ACTIVE 13
`define PCILSR_SS_DLL_CHANGED 8
`define PCILSR_SC_CMD_CPL_EN 4
`define PCILSR_SC_HP_INT_EN 5
`define PCILSR_SC_LATCH_EN 2
// ---------------------------------------------------------------
// fixed codes and reset values
// ---------------------------------------------------------------
`define PCILSR_SPEED_2G5 4'h1
`define PCILSR_SPEED_5G0 4'h2
`define PCILSR_MAX_SPEED 4'h2
`define PCILSR_ASPM_SUPPORT 2'h1
`define PCILSR_L0S_EXIT_LAT 3'h3
`define PCILSR_L1_EXIT_LAT 3'h0
`define PCILSR_PWR_LIMIT_RST 8'h19
`define PCILSR_PWR_SCALE_RST 2'h0
`define PCILSR_LINK_CTL_RST 16'h0000
`define PCILSR_NEG_WIDTH_RST 6'h01
`define PCILSR_FTS_EXT 16'h1000
`define PCILSR_TS1_EXT 16'h0400
`endif

// ==== tb/pcilsr_link_peer.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcilsr_link_peer
  import pcilsr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic retrain_req,
  input wire logic link_disable,
  input wire logic fail_next,
  output logic training_active,
  output logic training_failed,
  output logic link_in_l0,
  output logic dl_active,
  output pcilsr_pkg::pcilsr_speed_t neg_speed,
  output pcilsr_pkg::pcilsr_width_t neg_width
);
  logic [3:0] cnt;
  // fixed x4; speed only rises once the link is up
  assign neg_speed = link_in_l0 ? 4'h2 : 4'h1;
  assign neg_width = 6'h04;
  always_ff @(posedge clk) begin
    training_failed <= 1'b0;
    if (!resetn || link_disable) begin
      cnt <= 4'h0;
      training_active <= 1'b0;
      link_in_l0 <= 1'b0;
      dl_active <= 1'b0;
    end else if (retrain_req) begin
      cnt <= 4'h6;
      training_active <= 1'b1;
      link_in_l0 <= 1'b0;
      dl_active <= 1'b0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        training_active <= 1'b0;
        training_failed <= fail_next;
        link_in_l0 <= !fail_next;
        dl_active <= !fail_next;
      end
    end
  end
endmodule : pcilsr_link_peer
`default_nettype wire

// ==== tb/pcilsr_port_regs_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcilsr_port_regs_monitor
  import pcilsr_pkg::*;
#(
  parameter bit UPSTREAM = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic link_disable,
  input wire logic retrain_req,
  input wire logic rx_l0s_allowed,
  input wire logic [15:0] fts_count,
  input wire logic [15:0] ts1_count,
  input wire logic clkreq_hold_low,
  input wire logic slot_power_off,
  input wire logic pwr_limit_msg,
  input wire logic attn_ind_msg,
  input wire pcilsr_pkg::pcilsr_ind_e attn_ind,
  input wire logic pwr_ind_msg,
  input wire pcilsr_pkg::pcilsr_ind_e pwr_ind
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ----
  // write requests
  // ----
  sequence lc_wr;
    cfg_req && cfg_we && cfg_addr[11:2] == 10'h01e && cfg_be[0];
  endsequence
  sequence lc_hi_wr;
    cfg_req && cfg_we && cfg_addr[11:2] == 10'h01e && cfg_be[1];
  endsequence
  sequence sc_wr;
    cfg_req && cfg_we && cfg_addr[11:2] == 10'h020 && !UPSTREAM;
  endsequence
  sequence cap_wr;
    cfg_req && cfg_we && cfg_addr[11:2] == 10'h01f && cfg_be[2:0] != 3'h0 && !UPSTREAM;
  endsequence
  retrain_pulse_a: assert property (lc_wr ##0 (cfg_wdata[5] && !UPSTREAM) |=> retrain_req ##1 !retrain_req)
    else $error("retrain pulse missing");
  link_off_a: assert property (lc_wr |=> link_disable == (!UPSTREAM && $past(cfg_wdata[4])))
    else $error("link disable wrong");
  rx_l0s_on_a: assert property (rx_l0s_allowed)
    else $error("receiver l0s blocked");
  sync_counts_a: assert property (lc_wr |=>
    fts_count == ($past(cfg_wdata[7]) ? 16'h1000 : 16'h0) && ts1_count == ($past(cfg_wdata[7]) ? 16'h0400 : 16'h0))
    else $error("sync counts wrong");
  clkreq_ctl_a: assert property (lc_hi_wr |=> clkreq_hold_low == (UPSTREAM && !$past(cfg_wdata[8])))
    else $error("clock request hold wrong");
  attn_msg_a: assert property (sc_wr ##0 cfg_be[0] |=> attn_ind_msg && attn_ind == $past(cfg_wdata[7:6]))
    else $error("attention message wrong");
  pwr_msg_a: assert property (sc_wr ##0 cfg_be[1] |=> pwr_ind_msg && pwr_ind == $past(cfg_wdata[9:8]))
    else $error("power indicator message wrong");
  power_off_a: assert property (sc_wr ##0 cfg_be[1] |=> slot_power_off == $past(cfg_wdata[10]))
    else $error("slot power wrong");
  limit_msg_a: assert property (cap_wr |=> pwr_limit_msg)
    else $error("power limit message missing");
endmodule : pcilsr_port_regs_monitor
bind pcilsr_port_regs pcilsr_port_regs_monitor #(.UPSTREAM(UPSTREAM)) u_mon (
  .clk(clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
  .cfg_wdata(cfg_wdata), .link_disable(link_disable), .retrain_req(retrain_req), .rx_l0s_allowed(rx_l0s_allowed),
  .fts_count(fts_count), .ts1_count(ts1_count), .clkreq_hold_low(clkreq_hold_low),
  .slot_power_off(slot_power_off), .pwr_limit_msg(pwr_limit_msg), .attn_ind_msg(attn_ind_msg), .attn_ind(attn_ind),
  .pwr_ind_msg(pwr_ind_msg), .pwr_ind(pwr_ind)
);
`default_nettype wire

// ==== tb/tb_pcie_port_link_slot_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pcilsr_regs.svh"
module tb_pcie_port_link_slot_regs;
  import pcilsr_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, cfg_req = 1'b0, cfg_we = 1'b0, fail_next = 1'b0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [5:0] ev = 6'h00;
  logic [5:0] strap_w = 6'h08;
  logic strap_x = 1'b0;
  logic [31:0] up_rdata;
  logic up_disable, up_retrain, up_clkreq, up_hpint;
  logic [31:0] cfg_rdata, rd;
  logic cfg_ack, training_active, training_failed, link_in_l0, dl_active, link_disable, retrain_req;
  logic aspm_l0s_tx_en, aspm_l1_en, hotplug_int, slot_power_off;
  logic [15:0] fts_count, ts1_count;
  logic [7:0] lim_value;
  logic [1:0] lim_scale;
  logic [15:0] en [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0800, 16'h0010};
  pcilsr_speed_t neg_speed;
  pcilsr_width_t neg_width;
  pcilsr_ind_e attn_ind, pwr_ind;
  int n_fail = 0, check_count = 0, i;
  always #25 clk = ~clk;
  pcilsr_port_regs u_dut (
    .clk(clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .strap_max_width(strap_w),
    .strap_expander_present(strap_x), .neg_speed(neg_speed), .neg_width(neg_width),
    .training_active(training_active), .training_failed(training_failed), .link_in_l0(link_in_l0),
    .dl_active(dl_active), .ev_attention_button(ev[0]), .ev_power_fault(ev[1]), .ev_retention_latch(ev[2]),
    .ev_presence_change(ev[3]), .ev_electromech_lock(ev[4]), .ev_cmd_completed(ev[5]),
    .link_disable(link_disable), .retrain_req(retrain_req), .aspm_l0s_tx_en(aspm_l0s_tx_en),
    .aspm_l1_en(aspm_l1_en), .rx_l0s_allowed(), .fts_count(fts_count), .ts1_count(ts1_count),
    .clkreq_hold_low(), .hotplug_int(hotplug_int), .slot_power_off(slot_power_off), .pwr_limit_msg(),
    .pwr_limit_value(lim_value), .pwr_limit_scale(lim_scale), .attn_ind_msg(), .attn_ind(attn_ind),
    .pwr_ind_msg(), .pwr_ind(pwr_ind)
  );
  // upstream twin on the same bus: forced-zero controls and clock request hold
  pcilsr_port_regs #(.UPSTREAM(1'b1)) u_up (
    .clk(clk), .resetn(resetn), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(up_rdata), .cfg_ack(), .strap_max_width(strap_w),
    .strap_expander_present(strap_x), .neg_speed(neg_speed), .neg_width(neg_width),
    .training_active(training_active), .training_failed(training_failed), .link_in_l0(link_in_l0),
    .dl_active(dl_active), .ev_attention_button(ev[0]), .ev_power_fault(ev[1]), .ev_retention_latch(ev[2]),
    .ev_presence_change(ev[3]), .ev_electromech_lock(ev[4]), .ev_cmd_completed(ev[5]),
    .link_disable(up_disable), .retrain_req(up_retrain), .aspm_l0s_tx_en(), .aspm_l1_en(), .rx_l0s_allowed(),
    .fts_count(), .ts1_count(), .clkreq_hold_low(up_clkreq), .hotplug_int(up_hpint), .slot_power_off(),
    .pwr_limit_msg(), .pwr_limit_value(), .pwr_limit_scale(), .attn_ind_msg(), .attn_ind(), .pwr_ind_msg(),
    .pwr_ind()
  );
  pcilsr_link_peer u_peer (
    .clk(clk), .resetn(resetn), .retrain_req(retrain_req), .link_disable(link_disable), .fail_next(fail_next),
    .training_active(training_active), .training_failed(training_failed), .link_in_l0(link_in_l0),
    .dl_active(dl_active), .neg_speed(neg_speed), .neg_width(neg_width)
  );
  // ----
  // access and check tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_we <= we;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_req <= 1'b0;
    #1;
    chk({31'h0, cfg_ack}, 32'h1);
    rd = cfg_rdata;
  endtask : acc
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    acc(1'b0, a, 4'hf, 32'h0);
    chk(rd & m, e);
  endtask : rdc
  // bounded: a stuck training shows up as a status mismatch later
  task automatic settle;
    @(posedge clk);
    #1;
    for (int k = 0; k < 20 && training_active !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
  endtask : settle
  task automatic pulse(input int k);
    @(posedge clk);
    ev <= 6'h01 << k;
    @(posedge clk);
    ev <= 6'h00;
    #1;
  endtask : pulse
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdc(`PCILSR_OFF_LINK_CAP, 32'h0007ffff, 32'h00003482);
    chk(up_rdata & 32'h0007ffff, 32'h00043482);
    rdc(`PCILSR_OFF_LINK_CTL, 32'h2fffffff, 32'h00410000);
    rdc(`PCILSR_OFF_SLOT_CAP, 32'h0001ffc0, 32'h00000c80);
    rdc(`PCILSR_OFF_SLOT_CTL, 32'h0100ffff, 32'h000001c0);
    chk(up_rdata, 32'h0);
    rdc(12'h084, 32'hffffffff, 32'h0);
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      acc(1'b1, `PCILSR_OFF_LINK_CTL, 4'h1, 32'h80 | 32'(i));
      chk({30'h0, aspm_l1_en, aspm_l0s_tx_en}, 32'(i));
      chk({fts_count, ts1_count}, 32'h10000400);
    end
    acc(1'b1, `PCILSR_OFF_LINK_CTL, 4'h3, 32'h0010);
    chk({13'h0, up_clkreq, up_disable, link_disable, fts_count}, 32'h00050000);
    acc(1'b1, `PCILSR_OFF_LINK_CTL, 4'h3, 32'h0100);
    chk({30'h0, up_clkreq, link_disable}, 32'h0);
    $display("test link control done");
    fail_next <= 1'b1;
    acc(1'b1, `PCILSR_OFF_LINK_CTL, 4'h1, 32'h20);
    chk({30'h0, up_retrain, retrain_req}, 32'h1);
    @(posedge clk);
    rdc(`PCILSR_OFF_LINK_CTL, 32'h0c000020, 32'h08000000);
    settle;
    rdc(`PCILSR_OFF_LINK_CTL, 32'h0c000000, 32'h04000000);
    fail_next <= 1'b0;
    acc(1'b1, `PCILSR_OFF_LINK_CTL, 4'h1, 32'h20);
    settle;
    rdc(`PCILSR_OFF_LINK_CTL, 32'h2fff0000, 32'h20420000);
    acc(1'b1, `PCILSR_OFF_SLOT_CTL, 4'h8, 32'h0);
    rdc(`PCILSR_OFF_SLOT_CTL, 32'h01000000, 32'h01000000);
    acc(1'b1, `PCILSR_OFF_SLOT_CTL, 4'h8, 32'h01000000);
    rdc(`PCILSR_OFF_SLOT_CTL, 32'h01000000, 32'h0);
    acc(1'b1, `PCILSR_OFF_LINK_CTL, 4'h1, 32'h20);
    settle;
    rdc(`PCILSR_OFF_SLOT_CTL, 32'h01000000, 32'h01000000);
    $display("test retrain done");
    for (i = 0; i < 6; i++) begin
      acc(1'b1, `PCILSR_OFF_SLOT_CTL, 4'h3, 32'h1e0 | en[i]);
      pulse(i);
      chk({30'h0, up_hpint, hotplug_int}, 32'h1);
      acc(1'b1, `PCILSR_OFF_SLOT_CTL, 4'h3, 32'h1c0 | en[i]);
      pulse(i);
      chk({30'h0, up_hpint, hotplug_int}, 32'h0);
    end
    acc(1'b1, `PCILSR_OFF_SLOT_CTL, 4'h2, 32'h0500);
    chk({31'h0, slot_power_off}, 32'h1);
    for (i = 1; i < 4; i++) begin
      acc(1'b1, `PCILSR_OFF_SLOT_CTL, 4'h3, 32'(i * 320));
      chk({28'h0, attn_ind, pwr_ind}, 32'(i * 5));
    end
    acc(1'b1, `PCILSR_OFF_SLOT_CAP, 4'h7, 32'h9500);
    chk({22'h0, lim_scale, lim_value}, 32'h0000012a);
    rdc(`PCILSR_OFF_SLOT_CAP, 32'h0001ffc0, 32'h00009500);
    $display("test slot control done");
    // second reset with new straps: straps are caught only after a release
    @(posedge clk);
    strap_w <= 6'h04;
    strap_x <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdc(`PCILSR_OFF_LINK_CAP, 32'h000003f0, 32'h00000040);
    rdc(`PCILSR_OFF_SLOT_CAP, 32'h0001ffc0, 32'h00000cc0);
    rdc(`PCILSR_OFF_SLOT_CTL, 32'h0000ffff, 32'h000001c0);
    $display("test strap reload done");
    close_out;
  end
endmodule : tb_pcie_port_link_slot_regs
`default_nettype wire
